// ===== logic/psram_pkg.sv
// Package with constants and carrier types for the burst write device logic.
package psram_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 23;
  localparam int COL_W = 7;
  // Bus configuration register field positions.
  localparam int CFG_W = 16;
  localparam int CFG_MODE_BIT = 15;
  localparam int CFG_LAT_HI = 13;
  localparam int CFG_LAT_LO = 11;
  localparam int CFG_FIXED_BIT = 14;
  localparam int CFG_WAIT_EARLY_BIT = 8;
  localparam int CFG_WRAP_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h9D1F;
  // Timing and write buffer depth.
  localparam int CLK_MHZ = 10;
  localparam int SEL_LOW_MAX_US = 4;
  localparam int SEL_LOW_MAX_CYC = SEL_LOW_MAX_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 16;

  // One write word leaving the link side toward the array.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0] lane_n;
  } wr_word_t;

  // Controller pins after synchronisation.
  typedef struct packed {
    logic sel_n;
    logic avs_n;
    logic we_n;
    logic [1:0] lane_n;
    logic link_clk;
  } pins_t;
endpackage

// ===== logic/psram_wfifo.sv
// Parameterised write word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module psram_wfifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t st;
  fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Handshakes and honest full and empty.
  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update.
  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage written at the write pointer.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end
endmodule

// ===== logic/psram_burst_write.sv
// Burst and asynchronous write front end of the pseudo-static memory.
`timescale 1ns/1ps
module psram_burst_write
  import psram_pkg::*;
#(
  parameter int SEL_LOW_LIMIT = psram_pkg::SEL_LOW_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic address_valid_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] byte_lane_selects_n,
  input wire logic [psram_pkg::ADDR_W-1:0] addr,
  input wire logic [psram_pkg::DATA_W-1:0] dq_in,
  input wire logic cfg_write,
  input wire logic [psram_pkg::CFG_W-1:0] cfg_data,
  output logic [psram_pkg::CFG_W-1:0] bus_config_register,
  output logic stall,
  output logic stall_oe,
  output logic select_low_overrun,
  output psram_pkg::wr_word_t array_word,
  output logic array_valid,
  input wire logic array_ready,
  output logic fifo_full
);
  import psram_pkg::*;

  // Idle levels of the controller pins; the link clock stands low.
  localparam pins_t PINS_IDLE = '{sel_n: 1'b1, avs_n: 1'b1, we_n: 1'b1,
                                  lane_n: 2'b11, link_clk: 1'b0};

  typedef enum logic [2:0] {
    IDLE, LATENCY, BURST, ROW_END, ASYNC_WR, DONE
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [CFG_W-1:0] cfg;
    logic [ADDR_W-1:0] addr;
    logic [3:0] lat_cnt;
    logic [2:0] row_cnt;
    logic stall;
    logic active;
    logic first_done;
    logic [15:0] low_cnt;
    logic overrun;
    logic fixed_burst;
    logic link_q;
    logic async_arm;
    logic [1:0] lane_q;
    wr_word_t push_word;
    logic push;
  } state_t;

  state_t st;
  state_t next_st;
  pins_t sync1;
  pins_t sync2;
  pins_t raw;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic link_rise;
  logic sel_low;
  logic [2:0] lat_field;
  logic wrap_on;
  logic async_end;
  logic fifo_ready;
  logic [$bits(wr_word_t)-1:0] fifo_out;

  // Gather the pins so that they share one two-stage synchroniser.
  assign raw = '{sel_n: chip_select_n, avs_n: address_valid_strobe_n,
                 we_n: write_strobe_n, lane_n: byte_lane_selects_n,
                 link_clk: link_clk};

  // Two flip-flop synchroniser on every pin from the controller.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle levels keep a false link edge from following reset.
      sync1 <= PINS_IDLE;
      sync2 <= PINS_IDLE;
      addr_s1 <= '0;
      addr_s2 <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      addr_s1 <= addr;
      addr_s2 <= addr_s1;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  assign link_rise = sync2.link_clk && !st.link_q;
  assign sel_low = !sync2.sel_n;
  assign lat_field = st.cfg[CFG_LAT_HI:CFG_LAT_LO];
  assign wrap_on = st.cfg[CFG_WRAP_BIT];
  // Any of select, lane selects or write strobe may close the write.
  assign async_end = sync2.sel_n || (&sync2.lane_n) || sync2.we_n;

  // Next state of the whole front end.
  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    next_st.link_q = sync2.link_clk;
    if (cfg_write) begin
      next_st.cfg = cfg_data;
    end
    // Select-low watchdog flags a controller that starves refresh.
    if (sel_low) begin
      if (st.low_cnt != 16'hFFFF) next_st.low_cnt = st.low_cnt + 16'h0001;
      if (st.low_cnt >= 16'(SEL_LOW_LIMIT)) next_st.overrun = 1'b1;
    end else begin
      next_st.low_cnt = '0;
    end
    if (!sel_low) begin
      // A select-timed write closes here, so its word is pushed first.
      if (st.phase == ASYNC_WR && st.async_arm) begin
        next_st.push = 1'b1;
        next_st.push_word = '{addr: st.addr, data: dq_s2,
                              lane_n: st.lane_q};
      end
      // Select high ends any operation and is a refresh opportunity.
      next_st.phase = IDLE;
      next_st.stall = 1'b0;
      next_st.active = 1'b0;
      next_st.async_arm = 1'b0;
    end else begin
      case (st.phase)
        IDLE, DONE: begin
          // Any of the three strobes may time the write, so none of them
          // is required to be high when the address strobe is seen.
          if (!sync2.avs_n && st.cfg[CFG_MODE_BIT] &&
              !sync2.link_clk) begin
            next_st.phase = ASYNC_WR;
            next_st.addr = addr_s2;
          end else if (!sync2.avs_n && link_rise && !st.cfg[CFG_MODE_BIT]
                       && !sync2.we_n) begin
            // Burst write starts; stall covers the latency.
            next_st.phase = LATENCY;
            next_st.addr = addr_s2;
            next_st.lat_cnt = {1'b0, lat_field};
            next_st.stall = (lat_field != 3'h0);
            next_st.first_done = 1'b0;
            next_st.fixed_burst = !st.cfg[CFG_FIXED_BIT];
          end
        end
        LATENCY: begin
          if (link_rise) begin
            next_st.lat_cnt = st.lat_cnt - 4'h1;
            if (st.lat_cnt <= 4'h1) begin
              next_st.phase = BURST;
              next_st.stall = 1'b0;
            end
          end
        end
        BURST: begin
          if (link_rise) begin
            if (!sync2.avs_n && st.first_done) begin
              // New burst interrupts after the first word is in.
              next_st.phase = LATENCY;
              next_st.addr = addr_s2;
              next_st.lat_cnt = {1'b0, lat_field};
              next_st.stall = (lat_field != 3'h0);
              next_st.first_done = 1'b0;
            end else if (fifo_ready) begin
              next_st.push = 1'b1;
              next_st.push_word = '{addr: st.addr, data: dq_s2,
                                    lane_n: sync2.lane_n};
              next_st.first_done = 1'b1;
              next_st.addr = st.addr + ADDR_W'(1);
              if (!wrap_on && (&st.addr[COL_W-1:0])) begin
                // Last word of the row taken in the cycle stall rises.
                next_st.phase = ROW_END;
                next_st.stall = 1'b1;
                next_st.row_cnt = '0;
              end
            end
          end else if (!sync2.avs_n && sync2.we_n && st.fixed_burst &&
                       st.first_done && !sync2.link_clk) begin
            // With the clock still, a strobe fall after a fixed burst
            // opens asynchronous work without a select release.
            next_st.phase = ASYNC_WR;
            next_st.addr = addr_s2;
          end
        end
        ROW_END: begin
          // Stall holds until the controller lifts select.
          if (link_rise && st.row_cnt != 3'h7) begin
            next_st.row_cnt = st.row_cnt + 3'h1;
          end
        end
        ASYNC_WR: begin
          // Lanes are held from the armed cycles, since a lane-timed write
          // ends with both lanes already released.
          if (!sync2.we_n && !(&sync2.lane_n)) begin
            next_st.async_arm = 1'b1;
            next_st.lane_q = sync2.lane_n;
          end
          if (st.async_arm && async_end) begin
            next_st.push = 1'b1;
            next_st.push_word = '{addr: st.addr, data: dq_s2,
                                  lane_n: st.lane_q};
            next_st.async_arm = 1'b0;
            next_st.phase = DONE;
            next_st.fixed_burst = 1'b0;
          end
        end
        default: begin
          next_st.phase = IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{phase: IDLE, cfg: CFG_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Write words pass through the buffer; a full buffer stalls the link during a burst.
  psram_wfifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_data(st.push_word),
    .in_valid(st.push),
    .in_ready(fifo_ready),
    .out_data(fifo_out),
    .out_valid(array_valid),
    .out_ready(array_ready)
  );

  assign array_word = wr_word_t'(fifo_out);
  assign fifo_full = !fifo_ready;
  assign bus_config_register = st.cfg;
  // Stall is driven while selected, with buffer back-pressure added.
  assign stall = st.stall || (st.phase == BURST && !fifo_ready);
  assign stall_oe = sel_low;
  assign select_low_overrun = st.overrun;

  // Stall lasts exactly the latency count in link clocks.
  property lat_len_p;
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase == LATENCY && link_rise && st.lat_cnt <= 4'h1 && sel_low)
      |=> !st.stall;
  endproperty
  latency_stall_end_a: assert property (lat_len_p)
    else $error("Stall did not drop after latency.");
  latency_field_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase inside {IDLE, DONE} && next_st.phase == LATENCY)
      |=> st.lat_cnt == {1'b0, $past(lat_field)})
    else $error("Latency not loaded from field.");
  latency_stall_hold_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase == LATENCY && st.lat_cnt != 4'h0) |-> stall)
    else $error("Stall dropped during latency.");
  row_end_stall_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    st.phase == ROW_END |-> stall)
    else $error("No stall at row end.");
  row_last_word_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ($rose(st.phase == ROW_END)) |-> st.push)
    else $error("Last row word not taken.");
  interrupt_after_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase == BURST && next_st.phase == LATENCY) |-> st.first_done)
    else $error("Interrupt before first word.");
  async_start_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase == BURST && next_st.phase == ASYNC_WR)
      |-> (st.fixed_burst && !sync2.avs_n))
    else $error("Async start outside a fixed burst.");
  async_close_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (st.phase == ASYNC_WR && st.async_arm && async_end) |=> st.push)
    else $error("Async write not captured.");
  release_idle_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !sel_low |=> (st.phase == IDLE && !st.stall))
    else $error("Select high did not idle.");
  overrun_flag_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sel_low && st.low_cnt >= 16'(SEL_LOW_LIMIT)) |=> select_low_overrun)
    else $error("Select low overrun not flagged.");
  overrun_sticky_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    select_low_overrun |=> select_low_overrun)
    else $error("Overrun flag cleared without reset.");
  cover_burst_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    st.phase == LATENCY ##[1:200] st.phase == BURST);
  cover_row_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    (st.phase == ROW_END && st.row_cnt == 3'h2) ##1 st.phase == IDLE);
  cover_fixed_async_c: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    st.phase == BURST ##1 st.phase == ASYNC_WR);
  cover_async_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    st.phase == ASYNC_WR ##[1:50] st.phase == DONE);
endmodule

// ===== dv/psram_ctrl_model.sv
// Memory controller model that drives the write path pins of the device.
`timescale 1ns/1ps
module psram_ctrl_model
  import psram_pkg::*;
(
  input wire logic core_clk,
  input wire logic stall,
  output logic link_clk,
  output logic sel_n,
  output logic avs_n,
  output logic we_n,
  output logic [1:0] lane_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq
);
  // Idle pins; the link clock stands low outside frames.
  initial begin
    link_clk = 1'b0;
    addr = '0;
    dq = '0;
    release_sel();
  end
  // One link clock period; a word is shown only while stall is low.
  task automatic rise(input logic [DATA_W-1:0] d, output logic st);
    repeat (4) @(negedge core_clk);
    st = stall;
    dq = st ? ~d : d;
    link_clk = 1'b1;
    repeat (4) @(negedge core_clk);
    link_clk = 1'b0;
  endtask
  // Deselects for four cycles, far above the refresh opportunity time.
  task automatic release_sel();
    sel_n = 1'b1;
    avs_n = 1'b1;
    we_n = 1'b1;
    lane_n = 2'b11;
    dq = ~dq;
    repeat (4) @(negedge core_clk);
  endtask
  // Burst write of up to n words; it gives up after two stalled clocks once a word is sent, or after ten latency clocks.
  task automatic burst(input logic [ADDR_W-1:0] a, input int n,
      input logic [DATA_W-1:0] d0, input bit keep,
      output int lat, output int sent);
    logic st;
    int hold = 0;
    lat = 0;
    sent = 0;
    @(negedge core_clk);
    sel_n = 1'b0;
    avs_n = 1'b0;
    we_n = 1'b0;
    lane_n = 2'b00;
    addr = a;
    rise(~d0, st);
    avs_n = 1'b1;
    while (sent < n && hold < 2 && lat < 10) begin
      rise(d0 + DATA_W'(sent), st);
      if (!st) sent++;
      else if (sent == 0) lat++;
      else hold++;
    end
    if (!keep) release_sel();
  endtask
  // Async write ended by select (0), lane selects (1) or write strobe (2).
  task automatic async_wr(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int m);
    @(negedge core_clk);
    addr = a;
    dq = d;
    avs_n = 1'b0;
    sel_n = (m == 0);
    lane_n = {2{m == 1}};
    we_n = (m == 2);
    repeat (2) @(negedge core_clk);
    sel_n = 1'b0;
    lane_n = 2'b00;
    we_n = 1'b0;
    repeat (6) @(negedge core_clk);
    if (m == 0) sel_n = 1'b1;
    else if (m == 1) lane_n = 2'b11;
    else we_n = 1'b1;
    repeat (3) @(negedge core_clk);
    // No read follows on this path, so select always rises here.
    release_sel();
  endtask
endmodule

// ===== dv/psram_burst_write_bench.sv
// Self-checking bench for the burst write front end of the memory.
`timescale 1ns/1ps
module psram_burst_write_bench;
  import psram_pkg::*;
  localparam int SEL_LIM = 150;
  logic core_clk, arst_n, cfg_write, array_ready, link_clk, sel_n;
  logic avs_n, we_n, stall, stall_oe, overrun, vld, full;
  logic [1:0] lane_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq;
  logic [CFG_W-1:0] cfg_data, cfg_q;
  wr_word_t word, got[$];
  int error_cnt = 0, checked = 0, lat, sent;
  psram_burst_write #(.SEL_LOW_LIMIT(SEL_LIM)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk),
    .chip_select_n(sel_n), .address_valid_strobe_n(avs_n),
    .write_strobe_n(we_n), .byte_lane_selects_n(lane_n), .addr(addr),
    .dq_in(dq), .cfg_write(cfg_write), .cfg_data(cfg_data),
    .bus_config_register(cfg_q), .stall(stall), .stall_oe(stall_oe),
    .select_low_overrun(overrun), .array_word(word), .array_valid(vld),
    .array_ready(array_ready), .fifo_full(full)
  );
  psram_ctrl_model ctrl_u (
    .core_clk(core_clk), .stall(stall), .link_clk(link_clk), .sel_n(sel_n),
    .avs_n(avs_n), .we_n(we_n), .lane_n(lane_n), .addr(addr), .dq(dq)
  );
  // Core clock with a 100 ns period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Collects each word that the array side accepts.
  always @(posedge core_clk)
    if (vld === 1'b1 && array_ready === 1'b1) got.push_back(word);
  // Compares one value and reports a difference at once.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Loads the configuration word with mode, latency and wrap settings.
  task automatic set_cfg(input logic asy, fix, input logic [2:0] lc,
      input logic wrap);
    logic [CFG_W-1:0] v;
    v = {asy, fix, lc, CFG_RESET[10:4], wrap, CFG_RESET[2:0]};
    @(negedge core_clk);
    cfg_data = v;
    cfg_write = 1'b1;
    @(negedge core_clk);
    cfg_write = 1'b0;
    check(cfg_q, v);
  endtask
  // Pops n words and compares them with a run of addresses and data.
  task automatic expect_words(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int n);
    wr_word_t w;
    repeat (20) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      w = got.size() > 0 ? got.pop_front() : 'x;
      check({w.addr, w.data, w.lane_n},
            {a + ADDR_W'(i), d + DATA_W'(i), 2'b00});
    end
  endtask
  // Main sequence of tests.
  initial begin
    arst_n = 1'b0;
    cfg_write = 1'b0;
    cfg_data = '0;
    array_ready = 1'b1;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check(cfg_q, CFG_RESET);
    check({stall, stall_oe, full, overrun}, 4'h0);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      for (int lc = 2; lc < 8; lc += 2) begin
        set_cfg(1'b0, m[0], lc[2:0], 1'b1);
        ctrl_u.burst(23'h010, 4, 16'hA000, 1'b0, lat, sent);
        check(lat, lc);
        expect_words(23'h010, 16'hA000, 4);
      end
    end
    $display("test latency done");
    set_cfg(1'b0, 1'b0, 3'h3, 1'b0);
    ctrl_u.burst(23'h17D, 8, 16'h5500, 1'b0, lat, sent);
    check(sent, 3);
    check({stall, stall_oe}, 2'h0);
    expect_words(23'h17D, 16'h5500, 3);
    $display("test row end done");
    set_cfg(1'b0, 1'b1, 3'h2, 1'b1);
    ctrl_u.burst(23'h200, 2, 16'h1200, 1'b1, lat, sent);
    ctrl_u.burst(23'h300, 3, 16'h1300, 1'b0, lat, sent);
    check(lat, 2);
    expect_words(23'h200, 16'h1200, 2);
    expect_words(23'h300, 16'h1300, 3);
    $display("test interrupt done");
    // Fixed burst left selected, then a strobe-timed write without release.
    set_cfg(1'b0, 1'b0, 3'h2, 1'b1);
    ctrl_u.burst(23'h600, 1, 16'h2600, 1'b1, lat, sent);
    ctrl_u.async_wr(23'h610, 16'h2610, 2);
    expect_words(23'h600, 16'h2600, 1);
    expect_words(23'h610, 16'h2610, 1);
    $display("test fixed to async done");
    set_cfg(1'b1, 1'b0, 3'h2, 1'b1);
    for (int m = 0; m < 3; m++) begin
      ctrl_u.async_wr(ADDR_W'(9'h100 + m), DATA_W'(16'hC000 + m), m);
      expect_words(ADDR_W'(9'h100 + m), DATA_W'(16'hC000 + m), 1);
    end
    $display("test async done");
    // The long stalled burst also runs select low past the limit.
    check(overrun, 1'b0);
    set_cfg(1'b0, 1'b0, 3'h2, 1'b1);
    array_ready = 1'b0;
    ctrl_u.burst(23'h500, 20, 16'h7000, 1'b0, lat, sent);
    check(sent, FIFO_DEPTH);
    check({full, overrun}, 2'h3);
    array_ready = 1'b1;
    expect_words(23'h500, 16'h7000, FIFO_DEPTH);
    check({full, got.size()}, 33'h0);
    $display("test buffer done");
    complete_run();
  end
endmodule
